// ---- design/rdsm_mask_regs.sv ----
// Dip/swell interrupt enable masks for the per-channel RMS results,
// reached over AXI4-Lite, with one masked event request output.
// Assumes event conditions arrive as levels on aclk from the comparators.
//
// Operation
// - Bits 17,16 enable phase-3 current/voltage swell
// - Bits 15,14 enable phase-2 current/voltage swell
// - Bits 13,12 enable phase-1 current/voltage swell
// - Bits 11..6 enable extra channel dips
// - Bits 5..0 enable phase dips, fixed order
// - Half-cycle mask bits 31..24 read zero
// - Half-cycle bits 23..18 enable extra swells
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module rdsm_mask_regs (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Event conditions from the comparators
  input wire logic [17:0] full_cycle_rms_events,
  input wire logic [5:0] half_period_rms_swells,
  // Masked request towards the interrupt pins
  output logic dip_swell_irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [15:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [17:0] one_cycle_event_mask;
    logic [5:0] half_cycle_event_mask;
    logic irq;
  } rdsm_state_t;

  rdsm_state_t state;
  rdsm_state_t next_state;

  // ----------------------------------------------------------------
  // Named enables
  // ----------------------------------------------------------------
  // One signal per event source: each mask bit's position is fixed in
  // exactly one place, so a misplaced field shows up here alone
  logic ph3_current_swell_fc_en;
  logic ph3_voltage_swell_fc_en;
  logic ph2_current_swell_fc_en;
  logic ph2_voltage_swell_fc_en;
  logic ph1_current_swell_fc_en;
  logic ph1_voltage_swell_fc_en;
  logic extra5_dip_fc_en;
  logic extra4_dip_fc_en;
  logic extra3_dip_fc_en;
  logic extra2_dip_fc_en;
  logic extra1_dip_fc_en;
  logic extra0_dip_fc_en;
  logic ph3_current_dip_fc_en;
  logic ph3_voltage_dip_fc_en;
  logic ph2_current_dip_fc_en;
  logic ph2_voltage_dip_fc_en;
  logic ph1_current_dip_fc_en;
  logic ph1_voltage_dip_fc_en;
  logic extra5_swell_hc_en;
  logic extra4_swell_hc_en;
  logic extra3_swell_hc_en;
  logic extra2_swell_hc_en;
  logic extra1_swell_hc_en;
  logic extra0_swell_hc_en;
  logic [17:0] fc_enables;
  logic [5:0] hc_enables;

  // Phase swells judged on one-cycle RMS
  assign ph3_current_swell_fc_en =
    state.one_cycle_event_mask[rdsm_pkg::PH3_I_SWELL_FC];
  assign ph3_voltage_swell_fc_en =
    state.one_cycle_event_mask[rdsm_pkg::PH3_V_SWELL_FC];
  assign ph2_current_swell_fc_en =
    state.one_cycle_event_mask[rdsm_pkg::PH2_I_SWELL_FC];
  assign ph2_voltage_swell_fc_en =
    state.one_cycle_event_mask[rdsm_pkg::PH2_V_SWELL_FC];
  assign ph1_current_swell_fc_en =
    state.one_cycle_event_mask[rdsm_pkg::PH1_I_SWELL_FC];
  assign ph1_voltage_swell_fc_en =
    state.one_cycle_event_mask[rdsm_pkg::PH1_V_SWELL_FC];

  // Extra channel dips, channel 5 at the top
  assign extra5_dip_fc_en =
    state.one_cycle_event_mask[rdsm_pkg::EXTRA_DIP_FC_LSB + 5];
  assign extra4_dip_fc_en =
    state.one_cycle_event_mask[rdsm_pkg::EXTRA_DIP_FC_LSB + 4];
  assign extra3_dip_fc_en =
    state.one_cycle_event_mask[rdsm_pkg::EXTRA_DIP_FC_LSB + 3];
  assign extra2_dip_fc_en =
    state.one_cycle_event_mask[rdsm_pkg::EXTRA_DIP_FC_LSB + 2];
  assign extra1_dip_fc_en =
    state.one_cycle_event_mask[rdsm_pkg::EXTRA_DIP_FC_LSB + 1];
  assign extra0_dip_fc_en =
    state.one_cycle_event_mask[rdsm_pkg::EXTRA_DIP_FC_LSB];

  // Phase dips, phase 3 current at the top
  assign ph3_current_dip_fc_en =
    state.one_cycle_event_mask[rdsm_pkg::PHASE_DIP_FC_LSB + 5];
  assign ph3_voltage_dip_fc_en =
    state.one_cycle_event_mask[rdsm_pkg::PHASE_DIP_FC_LSB + 4];
  assign ph2_current_dip_fc_en =
    state.one_cycle_event_mask[rdsm_pkg::PHASE_DIP_FC_LSB + 3];
  assign ph2_voltage_dip_fc_en =
    state.one_cycle_event_mask[rdsm_pkg::PHASE_DIP_FC_LSB + 2];
  assign ph1_current_dip_fc_en =
    state.one_cycle_event_mask[rdsm_pkg::PHASE_DIP_FC_LSB + 1];
  assign ph1_voltage_dip_fc_en =
    state.one_cycle_event_mask[rdsm_pkg::PHASE_DIP_FC_LSB];

  // Extra channel swells judged on half-cycle RMS
  assign extra5_swell_hc_en =
    state.half_cycle_event_mask[5];
  assign extra4_swell_hc_en =
    state.half_cycle_event_mask[4];
  assign extra3_swell_hc_en =
    state.half_cycle_event_mask[3];
  assign extra2_swell_hc_en =
    state.half_cycle_event_mask[2];
  assign extra1_swell_hc_en =
    state.half_cycle_event_mask[1];
  assign extra0_swell_hc_en =
    state.half_cycle_event_mask[0];

  // Gathered back so that bit n lines up with event input n
  assign fc_enables = {
    ph3_current_swell_fc_en, ph3_voltage_swell_fc_en,
    ph2_current_swell_fc_en, ph2_voltage_swell_fc_en,
    ph1_current_swell_fc_en, ph1_voltage_swell_fc_en,
    extra5_dip_fc_en, extra4_dip_fc_en, extra3_dip_fc_en,
    extra2_dip_fc_en, extra1_dip_fc_en, extra0_dip_fc_en,
    ph3_current_dip_fc_en, ph3_voltage_dip_fc_en,
    ph2_current_dip_fc_en, ph2_voltage_dip_fc_en,
    ph1_current_dip_fc_en, ph1_voltage_dip_fc_en
  };
  assign hc_enables = {
    extra5_swell_hc_en, extra4_swell_hc_en, extra3_swell_hc_en,
    extra2_swell_hc_en, extra1_swell_hc_en, extra0_swell_hc_en
  };

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // 0: unmapped, 1: one-cycle mask, 2: half-cycle mask
  function automatic logic [1:0] decode(input logic [15:0] addr);
    if (addr[15:2] == rdsm_pkg::ONE_CYCLE_EVENT_MASK_IDX) begin
      decode = 2'h1;
    end else if (addr[15:2] == rdsm_pkg::HALF_CYCLE_EVENT_MASK_IDX) begin
      decode = 2'h2;
    end else begin
      decode = 2'h0;
    end
  endfunction

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old_word,
                                        input logic [31:0] new_word,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_word;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    merge = res;
  endfunction

  // Register images as software sees them; unimplemented bits read zero
  function automatic logic [31:0] image(input logic [1:0] sel,
                                        input logic [17:0] fc,
                                        input logic [5:0] hc);
    case (sel)
      2'h1: image = {14'h0000, fc};
      2'h2: image = {8'h00, hc, 18'h00000};
      default: image = 32'h00000000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] wsel;
    logic [1:0] rsel;
    logic [31:0] wword;
    wsel = 2'h0;
    rsel = 2'h0;
    wword = 32'h00000000;
    next_state = state;

    // Address and data are taken independently, in either order
    if (s_axi_awvalid && state.awready) begin
      next_state.aw_held = 1'b1;
      next_state.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state.wready) begin
      next_state.w_held = 1'b1;
      next_state.wdata = s_axi_wdata;
      next_state.wstrb = s_axi_wstrb;
    end

    // Write commits one cycle after both halves are held
    if (state.aw_held && state.w_held && !state.bvalid) begin
      wsel = decode(state.awaddr);
      wword = merge(image(wsel, state.one_cycle_event_mask,
                          state.half_cycle_event_mask),
                    state.wdata, state.wstrb);
      case (wsel)
        2'h1: begin
          // Swell enables 17..12, extra dips 11..6, phase dips 5..0
          next_state.one_cycle_event_mask = wword[rdsm_pkg::FC_W-1:0];
          next_state.bresp = rdsm_pkg::RESP_OKAY;
        end
        2'h2: begin
          // Reserved top byte is dropped so it always reads zero
          next_state.half_cycle_event_mask =
            wword[rdsm_pkg::HC_LSB +: rdsm_pkg::HC_W];
          next_state.bresp = rdsm_pkg::RESP_OKAY;
        end
        default: begin
          next_state.bresp = rdsm_pkg::RESP_SLVERR;
        end
      endcase
      next_state.bvalid = 1'b1;
      next_state.aw_held = 1'b0;
      next_state.w_held = 1'b0;
    end
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end
    // Hold off new halves until the response has gone
    next_state.awready = !next_state.aw_held && !next_state.bvalid;
    next_state.wready = !next_state.w_held && !next_state.bvalid;

    // Reads answer in the cycle after the address is taken
    if (s_axi_arvalid && state.arready) begin
      rsel = decode(s_axi_araddr);
      next_state.rdata = image(rsel, state.one_cycle_event_mask,
                               state.half_cycle_event_mask);
      next_state.rresp = (rsel == 2'h0) ? rdsm_pkg::RESP_SLVERR : rdsm_pkg::RESP_OKAY;
      next_state.rvalid = 1'b1;
    end
    if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end
    next_state.arready = !next_state.rvalid;

    // Events pass only through enabled mask bits
    next_state.irq = |(full_cycle_rms_events & fc_enables) |
                     |(half_period_rms_swells & hc_enables);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
      state.one_cycle_event_mask <= rdsm_pkg::ONE_CYCLE_EVENT_MASK_RST;
      state.half_cycle_event_mask <= rdsm_pkg::HALF_CYCLE_EVENT_MASK_RST;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = state.awready;
  assign s_axi_wready = state.wready;
  assign s_axi_bresp = state.bresp;
  assign s_axi_bvalid = state.bvalid;
  assign s_axi_arready = state.arready;
  assign s_axi_rdata = state.rdata;
  assign s_axi_rresp = state.rresp;
  assign s_axi_rvalid = state.rvalid;
  assign dip_swell_irq = state.irq;

endmodule // rdsm_mask_regs

`default_nettype wire

// ---- include/rdsm_pkg.sv ----
// Constants for the dip/swell interrupt mask block: register map,
// field positions, reset values and bus response codes.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package rdsm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // Printed offsets are word indices; the byte address is four times the index
  localparam int unsigned ADDR_W = 16;
  localparam logic [13:0] ONE_CYCLE_EVENT_MASK_IDX = 14'h0407;
  localparam logic [13:0] HALF_CYCLE_EVENT_MASK_IDX = 14'h0408;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int unsigned FC_W = 18;  // One-cycle mask bits 17..0
  localparam int unsigned HC_LSB = 18;  // Half-cycle swell bits 23..18
  localparam int unsigned HC_W = 6;
  localparam int unsigned PH3_I_SWELL_FC = 17;
  localparam int unsigned PH3_V_SWELL_FC = 16;
  localparam int unsigned PH2_I_SWELL_FC = 15;
  localparam int unsigned PH2_V_SWELL_FC = 14;
  localparam int unsigned PH1_I_SWELL_FC = 13;
  localparam int unsigned PH1_V_SWELL_FC = 12;
  localparam int unsigned EXTRA_DIP_FC_LSB = 6;  // Extra channels 5..0 at 11..6
  localparam int unsigned PHASE_DIP_FC_LSB = 0;  // Phase dips at 5..0

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [17:0] ONE_CYCLE_EVENT_MASK_RST = 18'h00000;
  localparam logic [5:0] HALF_CYCLE_EVENT_MASK_RST = 6'h00;

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- testbench/rdsm_mask_regs_properties.sv ----
// Assertions on the bus handshakes and the masked event request.
// Assumes it is bound to rdsm_mask_regs and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module rdsm_mask_regs_properties (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Events and request
  input wire logic [17:0] full_cycle_rms_events,
  input wire logic [5:0] half_period_rms_swells,
  input wire logic dip_swell_irq
);
  logic quiet;
  assign quiet = (full_cycle_rms_events == 18'h0) && (half_period_rms_swells == 6'h0);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  irq_reset_a: assert property ($rose(aresetn) |-> !dip_swell_irq)
    else $error("request high at reset release");
  irq_quiet_a: assert property ($past(quiet) |-> !dip_swell_irq)
    else $error("request without an event");
  rsvd_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:24] == 8'h00)
    else $error("reserved bits read nonzero");
  bad_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr != 16'h101c
    && s_axi_araddr != 16'h1020 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  wr_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
endmodule // rdsm_mask_regs_properties
bind rdsm_mask_regs rdsm_mask_regs_properties u_rdsm_mask_regs_properties (.*);
`default_nettype wire

// ---- testbench/rms_dip_swell_irq_mask_tb_top.sv ----
// Bench for the dip/swell mask block: AXI4-Lite tasks and a mask model.
// Assumes the checker file is compiled with it.
`timescale 1ns/100ps
`default_nettype none
module rms_dip_swell_irq_mask_tb_top;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dip_swell_irq;
  logic [17:0] full_cycle_rms_events = '0;
  logic [5:0] half_period_rms_swells = '0;
  int miscompares = 0, total_checks = 0, seed = 32'h114b, fcm = 0, hcm = 0;
  always #2.5 aclk = ~aclk;
  rdsm_mask_regs u_rdsm_mask_regs (.*);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic stall();
    miscompares++;
    test_done();
  endtask
  function automatic logic [31:0] resp(input logic [15:0] a);
    return (a == 16'h101c || a == 16'h1020) ? 32'h0 : 32'h2;
  endfunction
  // Ready raised after a random delay, so the slave must hold its answer
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    int dly;
    dly = $random(seed) & 3;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (n == dly) s_axi_bready <= 1'h1;
      if (s_axi_bvalid && s_axi_bready) break;
    end
    if (n == 40) stall();
    s_axi_bready <= 1'h0;
    chk(32'(s_axi_bresp), resp(a));
    for (int i = 0; i < 4; i++) begin
      if (s[i] && a == 16'h101c) fcm[i*8 +: 8] = d[i*8 +: 8];
      if (s[i] && a == 16'h1020) hcm[i*8 +: 8] = d[i*8 +: 8];
    end
    fcm = fcm & 32'h0003ffff;
    hcm = hcm & 32'h00fc0000;
  endtask
  task automatic rd(input logic [15:0] a);
    int n;
    int dly;
    dly = $random(seed) & 3;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (n == dly) s_axi_rready <= 1'h1;
      if (s_axi_rvalid && s_axi_rready) break;
    end
    if (n == 40) stall();
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, a == 16'h101c ? fcm : a == 16'h1020 ? hcm : 32'h0);
    chk(32'(s_axi_rresp), resp(a));
  endtask
  task automatic ev(input logic [17:0] f, input logic [5:0] h);
    @(posedge aclk);
    full_cycle_rms_events <= f;
    half_period_rms_swells <= h;
    repeat (2) @(posedge aclk);
    #1 chk(32'(dip_swell_irq), 32'(|(f & fcm[17:0]) | |(h & hcm[23:18])));
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    ev('1, '1);
    rd(16'h101c);
    rd(16'h1020);
    for (int b = 0; b < 24; b++) begin
      wr(16'h101c, 32'h1 << b, 4'hf);
      wr(16'h1020, 32'h1 << b, 4'hf);
      ev(18'(32'h1 << b), 6'((32'h1 << b) >> 18));
      ev(~18'(32'h1 << b), ~6'((32'h1 << b) >> 18));
    end
    wr(16'h1020, 32'hffffffff, 4'hf);
    rd(16'h1020);
    for (int k = 0; k < 40; k++) begin
      wr(16'h1018 + 16'(($random(seed) & 3) * 4), $random(seed), 4'($random(seed)));
      rd(16'h1018 + 16'(($random(seed) & 3) * 4));
      ev(18'($random(seed)), 6'($random(seed)));
    end
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    fcm = 0;
    hcm = 0;
    ev('1, '1);
    rd(16'h101c);
    test_done();
  end
endmodule // rms_dip_swell_irq_mask_tb_top
`default_nettype wire
